// file: include/eeprom_pkg.sv
package eeprom_pkg;
  localparam int          WORD_BITS       = 8;
  localparam int          ADDR_BITS       = 17;
  localparam int          LEN_BITS        = 9;
  localparam int          PAGE_BYTES      = 256;
  localparam int          PAGE_COUNT      = 512;
  localparam int          MEM_BYTES       = PAGE_BYTES * PAGE_COUNT;
  localparam int          FIFO_DEPTH      = 32;
  localparam logic [3:0]  DEV_PREFIX      = 4'ha;
  localparam logic [1:0]  DEV_UNUSED      = 2'h0;
  localparam logic [3:0]  BIT_ACK         = 4'h8;
  localparam logic [3:0]  RECOVERY_PULSES = 4'h9;
  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          CLK_MHZ         = 1000 / CLK_PERIOD_NS;
  localparam int          PROG_TIME_MS    = 5;
  localparam int          PROG_CYCLES_NOM = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int          SCL_PERIOD_NS   = 200;
  localparam logic [7:0]  SCL_QUARTER     = 8'(SCL_PERIOD_NS / (4 * CLK_PERIOD_NS));

  typedef logic [WORD_BITS-1:0] byte_t;
  typedef logic [ADDR_BITS-1:0] addr_t;
  typedef logic [LEN_BITS-1:0]  len_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_ADDRHI  = 3'h3,
    ST_ADDRLO  = 3'h2,
    ST_WRDATA  = 3'h6,
    ST_RDDATA  = 3'h7
  } dev_state_e;

  typedef enum logic [3:0] {
    C_IDLE    = 4'h0,
    C_START   = 4'h1,
    C_DEVADDR = 4'h3,
    C_ADDRHI  = 4'h2,
    C_ADDRLO  = 4'h6,
    C_WDATA   = 4'h7,
    C_RDATA   = 4'h5,
    C_STOP    = 4'h4,
    C_RECOVER = 4'hc
  } ctl_state_e;

  function automatic byte_t dev_addr_word(input logic pageSel, input logic rd);
    return {DEV_PREFIX, DEV_UNUSED, pageSel, rd};
  endfunction : dev_addr_word
endpackage : eeprom_pkg

// file: include/twi_bus_if.sv
`timescale 1ns/100ps
interface twi_bus_if;
  logic scl;
  logic sda;
  logic ctlSdaOut;
  logic ctlSdaOeN;
  logic devSdaOut;
  logic devSdaOeN;

  // Wired-AND with an external pull-up: released means high
  assign sda = ~((~ctlSdaOeN & ~ctlSdaOut) | (~devSdaOeN & ~devSdaOut));

  modport device(input scl, input sda, output devSdaOut, output devSdaOeN);
  modport controller(output scl, input sda, output ctlSdaOut, output ctlSdaOeN);
endinterface : twi_bus_if

// file: core/eeprom_device.sv
// Operation
// - Sample on SCL rise, launch after SCL fall
// - SDA open-drain, pull low or release
// - 512 pages of 256 bytes, 17-bit address
// - SDA change while SCL high is start/stop
// - SDA falling with SCL high is start
// - SDA rising with SCL high is stop
// - Stop after read enters standby
// - Every transfer is an 8-bit word
// - Acknowledge each received word in ninth clock
// - Standby at power-up and after stop, idle
// - Recovery: clock up to nine, then start
// - Full or partial page writes accepted
// - Self-timed programming cycle after write stop
// - No select pins, fixed address word only
// - Address word: prefix, zeros, page bit, read
// - Page write wraps low eight address bits
// - No acknowledge while programming runs
// - Address counter keeps last plus one
`timescale 1ns/100ps
module eeprom_device #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES_NOM   // Programming time in clk cycles
) (
  input  wire logic       clk,          // System clock, 200 MHz
  input  wire logic       rstn,         // Asynchronous reset, active low
  input  wire logic       ce,           // Clock enable, freezes all state when low
  twi_bus_if.device       bus,          // Two-wire bus pins
  output logic            standby,      // Idle and not programming
  output logic            programming   // Internal write cycle running
);
  import eeprom_pkg::*;

  byte_t               mem [MEM_BYTES];
  byte_t               pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask;
  logic                sclS1;
  logic                sclS2;
  logic                sclQ;
  logic                sdaS1;
  logic                sdaS2;
  logic                sdaQ;
  dev_state_e          state;
  logic [3:0]          bitCnt;
  byte_t               shiftIn;
  byte_t               txByte;
  addr_t               addrReg;
  addr_t               addrCnt;
  logic [31:0]         progCnt;
  logic                sdaOeN;
  logic                sclRise;
  logic                sclFall;
  logic                startCond;
  logic                stopCond;
  logic                rxDone;
  logic                addrMatch;
  logic                takeData;
  logic                clearPage;
  logic                startProg;
  logic                progDone;
  logic                committing;
  logic [7:0]          commitIdx;

  // The device only ever pulls low; the level on the wire comes from the pull-up
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOeN = sdaOeN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sclQ  <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaQ  <= 1'b1;
    end else if (ce) begin
      sclS1 <= bus.scl;
      sclS2 <= sclS1;
      sclQ  <= sclS2;
      sdaS1 <= bus.sda;
      sdaS2 <= sdaS1;
      sdaQ  <= sdaS2;
    end
  end

  assign sclRise   = sclS2 & ~sclQ;
  assign sclFall   = ~sclS2 & sclQ;
  // SCL high on both samples, so any SDA edge here is a condition, not data
  assign startCond = sclS2 & sclQ & sdaQ & ~sdaS2;
  assign stopCond  = sclS2 & sclQ & ~sdaQ & sdaS2;
  assign rxDone    = sclFall && (bitCnt == BIT_ACK);
  // Only the fixed pattern selects the part; page bit and direction are free
  assign addrMatch = ({shiftIn[7:2], 2'h0} == dev_addr_word(1'b0, 1'b0));
  assign takeData  = rxDone && (state == ST_WRDATA);
  assign clearPage = rxDone && (state == ST_ADDRLO);
  assign startProg = stopCond && (state == ST_WRDATA) && (|pageMask);
  assign progDone  = programming && (progCnt == 32'(PROG_CYCLES - 1));
  assign committing = programming && (progCnt < 32'(PAGE_BYTES));
  assign commitIdx = progCnt[7:0];
  assign standby   = (state == ST_IDLE) && !programming;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state   <= ST_IDLE;
      bitCnt  <= 4'h0;
      shiftIn <= 8'h00;
      txByte  <= 8'h00;
      addrReg <= '0;
      addrCnt <= '0;
    end else if (ce) begin
      if (startCond) begin
        state  <= ST_DEVADDR;
        bitCnt <= 4'h0;
      end else if (stopCond) begin
        state <= ST_IDLE;
      end else if (sclRise && state != ST_IDLE) begin
        if (bitCnt != BIT_ACK) begin
          bitCnt  <= bitCnt + 4'h1;
          shiftIn <= {shiftIn[6:0], sdaS2};
        end else begin
          bitCnt <= 4'h0;
          // Right after the address ack this sees our own low and reloads the same byte
          if (state == ST_RDDATA) begin
            if (sdaS2) begin
              state <= ST_IDLE;
            end else begin
              txByte <= mem[addrCnt];
            end
          end
        end
      end else if (rxDone) begin
        case (state)
          ST_DEVADDR: begin
            if (addrMatch && !programming) begin
              if (shiftIn[0]) begin
                state  <= ST_RDDATA;
                txByte <= mem[addrCnt];
              end else begin
                state       <= ST_ADDRHI;
                addrReg[16] <= shiftIn[1];
              end
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_ADDRHI: begin
            addrReg[15:8] <= shiftIn;
            state         <= ST_ADDRLO;
          end
          ST_ADDRLO: begin
            addrReg[7:0] <= shiftIn;
            addrCnt      <= {addrReg[16:8], shiftIn};
            state        <= ST_WRDATA;
          end
          ST_WRDATA: begin
            addrReg[7:0] <= addrReg[7:0] + 8'h01;
            addrCnt      <= {addrReg[16:8], addrReg[7:0] + 8'h01};
          end
          ST_RDDATA: begin
            addrCnt <= addrCnt + 1'b1;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdaOeN <= 1'b1;
    end else if (ce) begin
      if (startCond || stopCond) begin
        sdaOeN <= 1'b1;
      end else if (sclFall) begin
        if (bitCnt == BIT_ACK) begin
          sdaOeN <= !((state == ST_DEVADDR && addrMatch && !programming) ||
                      state == ST_ADDRHI || state == ST_ADDRLO ||
                      state == ST_WRDATA);
        end else if (state == ST_RDDATA) begin
          sdaOeN <= txByte[3'(4'h7 - bitCnt)];
        end else begin
          sdaOeN <= 1'b1;
        end
      end
    end
  end

  // Bytes collect in a page buffer and reach the array only after the stop,
  // so a write cut short by a new start leaves the array untouched
  always_ff @(posedge clk) begin
    if (ce) begin
      if (takeData) begin
        pageBuf[addrReg[7:0]] <= shiftIn;
      end
      if (committing && pageMask[commitIdx]) begin
        mem[{addrReg[16:8], commitIdx}] <= pageBuf[commitIdx];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pageMask <= '0;
    end else if (ce) begin
      if (clearPage || progDone) begin
        pageMask <= '0;
      end else if (takeData) begin
        pageMask[addrReg[7:0]] <= 1'b1;
      end
    end
  end

  // The commit walk uses the first 256 cycles, so PROG_CYCLES must not be shorter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      programming <= 1'b0;
      progCnt     <= '0;
    end else if (ce) begin
      if (startProg) begin
        programming <= 1'b1;
        progCnt     <= '0;
      end else if (programming) begin
        progCnt <= progCnt + 32'h1;
        if (progDone) begin
          programming <= 1'b0;
        end
      end
    end
  end
endmodule : eeprom_device

// file: core/bus_controller.sv
`timescale 1ns/100ps
module data_fifo #(
  parameter int WIDTH = 8,    // Word width
  parameter int DEPTH = 32    // Word count, power of two
) (
  input  wire logic             clk,       // System clock
  input  wire logic             rstn,      // Asynchronous reset, active low
  input  wire logic             ce,        // Clock enable
  input  wire logic             inValid,   // Write side valid
  output logic                  inReady,   // Not full
  input  wire logic [WIDTH-1:0] inData,    // Write data
  output logic                  outValid,  // Not empty
  input  wire logic             outReady,  // Read side takes a word
  output logic [WIDTH-1:0]      outData    // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;

  assign inReady  = !((wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
  assign outValid = (wrPtr != rdPtr);
  assign outData  = store[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (ce && inValid && inReady) begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else if (ce) begin
      if (inValid && inReady) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end
endmodule : data_fifo

module bus_controller (
  input  wire logic              clk,         // System clock, 200 MHz
  input  wire logic              rstn,        // Asynchronous reset, active low
  input  wire logic              ce,          // Clock enable
  twi_bus_if.controller          bus,         // Two-wire bus pins
  input  wire logic              cmdValid,    // Command offered
  output logic                   cmdReady,    // Idle, command taken
  input  wire logic              cmdRead,     // 1 read, 0 write
  input  wire logic              cmdRecover,  // Bus recovery instead of transfer
  input  wire eeprom_pkg::addr_t cmdAddr,     // Start address
  input  wire eeprom_pkg::len_t  cmdLen,      // Byte count, 1 to 256
  input  wire logic              wrValid,     // Write byte offered
  output logic                   wrReady,     // Write FIFO not full
  input  wire eeprom_pkg::byte_t wrData,      // Write byte
  output logic                   rdValid,     // Read byte pulse
  output eeprom_pkg::byte_t      rdData,      // Read byte
  output logic                   done,        // Transaction end pulse
  output logic                   nack         // Last transaction refused
);
  import eeprom_pkg::*;

  ctl_state_e state;
  logic [1:0] phase;
  logic [7:0] qCnt;
  logic [3:0] bitIdx;
  byte_t      txByte;
  byte_t      rxShift;
  addr_t      addr;
  len_t       lenLeft;
  logic       isRead;
  logic       reAddr;
  logic       recovering;
  logic       sclOut;
  logic       sdaOeN;
  logic       sdaS1;
  logic       sdaS2;
  logic       fifoValid;
  byte_t      fifoData;
  logic       fifoPop;
  logic       loadSlot;
  logic       stall;
  logic       tick;
  logic       advance;
  logic       accept;
  logic       txState;
  logic       txBit;

  data_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .inData   (wrData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  assign bus.scl       = sclOut;
  assign bus.ctlSdaOut = 1'b0;
  assign bus.ctlSdaOeN = sdaOeN;
  assign cmdReady      = (state == C_IDLE);
  assign accept        = cmdValid && cmdReady;
  // An empty FIFO stretches SCL low before the first bit of a data byte
  assign loadSlot = (state == C_WDATA) && (bitIdx == 4'h0) && (phase == 2'h3);
  assign stall    = loadSlot && !fifoValid;
  assign tick     = (state != C_IDLE) && (qCnt == SCL_QUARTER - 8'h01) && !stall;
  assign advance  = tick && (phase == 2'h2);
  assign fifoPop  = tick && loadSlot;
  assign txState  = (state == C_DEVADDR) || (state == C_ADDRHI) ||
                    (state == C_ADDRLO) || (state == C_WDATA);

  always_comb begin
    txBit = 1'b1;
    if (fifoPop) begin
      txBit = fifoData[7];
    end else if (state == C_RDATA && bitIdx == BIT_ACK) begin
      txBit = (lenLeft == 9'h001);
    end else if (txState && bitIdx != BIT_ACK) begin
      txBit = txByte[3'(4'h7 - bitIdx)];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
    end else if (ce) begin
      sdaS1 <= bus.sda;
      sdaS2 <= sdaS1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      qCnt  <= 8'h00;
      phase <= 2'h3;
    end else if (ce) begin
      if (accept) begin
        qCnt  <= 8'h00;
        phase <= 2'h3;
      end else if (tick) begin
        qCnt  <= 8'h00;
        phase <= phase + 2'h1;
      end else if (state != C_IDLE && !stall) begin
        qCnt <= qCnt + 8'h01;
      end
    end
  end

  // Data moves only in the low phases; SDA moves with SCL high only in start and stop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclOut <= 1'b1;
      sdaOeN <= 1'b1;
    end else if (ce && tick) begin
      case (phase + 2'h1)
        2'h0: begin
          sclOut <= 1'b0;
          sdaOeN <= (state == C_START) ? 1'b1 : (state == C_STOP) ? 1'b0 : txBit;
        end
        2'h1: sclOut <= 1'b1;
        2'h2: begin
          if (state == C_START) begin
            sdaOeN <= 1'b0;
          end else if (state == C_STOP) begin
            sdaOeN <= 1'b1;
          end
        end
        default: begin
          if (state != C_STOP) begin
            sclOut <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= C_IDLE;
      bitIdx     <= 4'h0;
      txByte     <= 8'h00;
      rxShift    <= 8'h00;
      addr       <= '0;
      lenLeft    <= '0;
      isRead     <= 1'b0;
      reAddr     <= 1'b0;
      recovering <= 1'b0;
      rdValid    <= 1'b0;
      rdData     <= 8'h00;
      done       <= 1'b0;
      nack       <= 1'b0;
    end else if (ce) begin
      rdValid <= 1'b0;
      done    <= 1'b0;
      if (accept) begin
        state      <= cmdRecover ? C_RECOVER : C_START;
        addr       <= cmdAddr;
        lenLeft    <= cmdLen;
        isRead     <= cmdRead;
        reAddr     <= 1'b0;
        recovering <= cmdRecover;
        bitIdx     <= 4'h0;
        nack       <= 1'b0;
      end else if (fifoPop) begin
        txByte <= fifoData;
      end else if (advance) begin
        case (state)
          C_START: begin
            bitIdx <= 4'h0;
            if (recovering) begin
              recovering <= 1'b0;
              state      <= C_STOP;
            end else begin
              state  <= C_DEVADDR;
              txByte <= dev_addr_word(addr[16], reAddr);
            end
          end
          C_DEVADDR, C_ADDRHI, C_ADDRLO, C_WDATA: begin
            if (bitIdx != BIT_ACK) begin
              bitIdx <= bitIdx + 4'h1;
            end else begin
              bitIdx <= 4'h0;
              if (sdaS2) begin
                nack  <= 1'b1;
                state <= C_STOP;
              end else if (state == C_DEVADDR) begin
                state  <= reAddr ? C_RDATA : C_ADDRHI;
                txByte <= addr[15:8];
              end else if (state == C_ADDRHI) begin
                state  <= C_ADDRLO;
                txByte <= addr[7:0];
              end else if (state == C_ADDRLO) begin
                state  <= isRead ? C_START : C_WDATA;
                reAddr <= isRead;
              end else begin
                lenLeft <= lenLeft - 9'h001;
                if (lenLeft == 9'h001) begin
                  state <= C_STOP;
                end
              end
            end
          end
          C_RDATA: begin
            if (bitIdx != BIT_ACK) begin
              bitIdx  <= bitIdx + 4'h1;
              rxShift <= {rxShift[6:0], sdaS2};
              if (bitIdx == 4'h7) begin
                rdValid <= 1'b1;
                rdData  <= {rxShift[6:0], sdaS2};
              end
            end else begin
              bitIdx  <= 4'h0;
              lenLeft <= lenLeft - 9'h001;
              if (lenLeft == 9'h001) begin
                state <= C_STOP;
              end
            end
          end
          C_RECOVER: begin
            if (sdaS2 || bitIdx == RECOVERY_PULSES - 4'h1) begin
              state <= C_START;
            end else begin
              bitIdx <= bitIdx + 4'h1;
            end
          end
          C_STOP: begin
            state <= C_IDLE;
            done  <= 1'b1;
          end
          default: state <= C_IDLE;
        endcase
      end
    end
  end
endmodule : bus_controller

// file: tb/twi_checker.sv
`timescale 1ns/100ps
module twi_checker (
  input wire logic clk,        // System clock
  input wire logic rstn,       // Reset, active low
  input wire logic scl,        // Link clock
  input wire logic sda,        // Resolved data line
  input wire logic ctlSdaOut,  // Controller drive value
  input wire logic ctlSdaOeN,  // Controller enable, low drives
  input wire logic devSdaOut,  // Device drive value
  input wire logic devSdaOeN   // Device enable, low drives
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  open_drain_a: assert property (!ctlSdaOut && !devSdaOut)
    else $error("a party drives the data line high");
  reset_idle_a: assert property ($rose(rstn) |-> scl && ctlSdaOeN && devSdaOeN)
    else $error("bus not idle after reset");
  dev_launch_a: assert property ($changed(devSdaOeN) |-> !scl && !$past(scl, 3))
    else $error("device changed data outside clock low");
  ack_hold_a: assert property ($fell(devSdaOeN) |-> (!devSdaOeN) [*8])
    else $error("device drive too short");
  dev_release_a: assert property ($fell(devSdaOeN) |-> ##[8:400] devSdaOeN)
    else $error("device kept the data line");
  clock_low_a: assert property ($fell(scl) |-> (!scl) [*8])
    else $error("clock low phase too short");
  start_seq_a: assert property (scl && $fell(sda) |-> (!sda) [*8] ##[1:5] !scl)
    else $error("start not followed by clock low");
  stop_seq_a: assert property (scl && $rose(sda) |-> scl [*8])
    else $error("clock moved right after stop");
endmodule : twi_checker

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import eeprom_pkg::*;
  // Long enough that a poll lands inside the write cycle
  localparam int PROG = 2000;
  logic  clk         = 1'b0;
  logic  rstn        = 1'b0;
  logic  ce          = 1'b1;
  logic  cmdValid    = 1'b0;
  logic  cmdRead     = 1'b0;
  logic  cmdRecover  = 1'b0;
  logic  wrValid     = 1'b0;
  addr_t cmdAddr     = 17'h00000;
  len_t  cmdLen      = 9'h001;
  byte_t wrData      = 8'h00;
  logic  cmdReady, wrReady, rdValid, done, nack, standby, programming;
  byte_t rdData;
  byte_t rdQ[$];
  int    num_errors  = 0;
  int    checks_done = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (rdValid) rdQ.push_back(rdData);

  twi_bus_if u_twi_bus_if ();
  eeprom_device #(.PROG_CYCLES(PROG)) u_eeprom_device (.clk(clk), .rstn(rstn), .ce(ce),
    .bus(u_twi_bus_if.device), .standby(standby), .programming(programming));
  bus_controller u_bus_controller (.clk(clk), .rstn(rstn), .ce(ce),
    .bus(u_twi_bus_if.controller), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdRead(cmdRead), .cmdRecover(cmdRecover), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
    .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
    .rdData(rdData), .done(done), .nack(nack));
  twi_checker u_twi_checker (.clk(clk), .rstn(rstn), .scl(u_twi_bus_if.scl),
    .sda(u_twi_bus_if.sda), .ctlSdaOut(u_twi_bus_if.ctlSdaOut),
    .ctlSdaOeN(u_twi_bus_if.ctlSdaOeN), .devSdaOut(u_twi_bus_if.devSdaOut),
    .devSdaOeN(u_twi_bus_if.devSdaOeN));

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic hang();
    chk("wait bound", 16'h1, 16'h0);
    conclude();
  endtask : hang

  task automatic run(input logic rd, input logic rec, input addr_t a, input len_t n,
                     input logic expNack);
    int k;
    @(posedge clk);
    cmdValid   <= 1'b1;
    cmdRead    <= rd;
    cmdRecover <= rec;
    cmdAddr    <= a;
    cmdLen     <= n;
    @(posedge clk);
    cmdValid   <= 1'b0;
    #1;
    chk("busy", 16'h0, cmdReady);
    for (k = 0; k < 50000 && done !== 1'b1; k++) @(posedge clk) #1;
    if (k == 50000) hang();
    chk("nack", expNack, nack);
    chk("ready", 16'h1, cmdReady);
  endtask : run

  task automatic push(input byte_t b);
    int k;
    @(posedge clk);
    wrValid <= 1'b1;
    wrData  <= b;
    for (k = 0; k < 50000; k++) begin
      #1;
      if (wrReady === 1'b1) break;
      @(posedge clk);
    end
    if (k == 50000) hang();
    @(posedge clk);
    wrValid <= 1'b0;
  endtask : push

  task automatic prog_wait(input int minLen);
    int k;
    chk("programming", 16'h1, programming);
    for (k = 0; k < 3 * PROG && programming === 1'b1; k++) @(posedge clk) #1;
    if (k == 3 * PROG) hang();
    chk("program length", 16'h1, k >= minLen && k <= PROG);
    chk("standby", 16'h1, standby);
  endtask : prog_wait

  task automatic standby_chk();
    int k;
    for (k = 0; k < 10 && standby !== 1'b1; k++) @(posedge clk) #1;
    chk("standby", 16'h1, standby);
    if (k == 10) conclude();
  endtask : standby_chk

  task automatic read_cmp(input addr_t a, input len_t n, input byte_t first);
    rdQ.delete();
    run(1'b1, 1'b0, a, n, 1'b0);
    chk("read count", n, rdQ.size());
    foreach (rdQ[i]) chk("read data", byte_t'(first + i), rdQ[i]);
  endtask : read_cmp

  // Partial page crossing the page end, then a poll during programming
  task automatic t_page_wrap();
    for (int i = 0; i < 3; i++) push(byte_t'(8'hc1 + i));
    run(1'b0, 1'b0, 17'h123fe, 9'h003, 1'b0);
    run(1'b1, 1'b0, 17'h123fe, 9'h001, 1'b1);
    prog_wait(0);
    read_cmp(17'h123fe, 9'h002, 8'hc1);
    read_cmp(17'h12300, 9'h001, 8'hc3);
    standby_chk();
  endtask : t_page_wrap

  // Buffer filled to refusal, then drained by a write longer than it
  task automatic t_fifo_full();
    for (int i = 0; i < 32; i++) push(byte_t'(8'h40 + i));
    @(posedge clk) #1;
    chk("buffer full", 16'h0, wrReady);
    fork
      run(1'b0, 1'b0, 17'h00020, 9'h022, 1'b0);
      begin
        push(8'h60);
        push(8'h61);
      end
    join
    // Both ends frozen for 100 cycles: the length check below fails unless the count paused
    @(posedge clk);
    ce <= 1'b0;
    repeat (100) @(posedge clk);
    ce <= 1'b1;
    prog_wait(PROG - 20);
    read_cmp(17'h00020, 9'h022, 8'h40);
  endtask : t_fifo_full

  // Empty buffer at the data slot: SCL waits low until the byte arrives
  task automatic t_stall();
    fork
      run(1'b0, 1'b0, 17'h10050, 9'h001, 1'b0);
      begin
        repeat (1500) @(posedge clk);
        push(8'h77);
      end
    join
    prog_wait(PROG - 20);
    read_cmp(17'h10050, 9'h001, 8'h77);
  endtask : t_stall

  task automatic t_recover();
    run(1'b0, 1'b1, 17'h00000, 9'h001, 1'b0);
    standby_chk();
    read_cmp(17'h00021, 9'h001, 8'h41);
  endtask : t_recover

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("standby", 16'h1, standby);
    t_page_wrap();
    t_fifo_full();
    t_recover();
    t_stall();
    conclude();
  end
endmodule : tb_top
